// >>> verilog/nvm_pkg.sv
/*
  shared constants and types for the two-wire nonvolatile row access front end.
  assumes a single 125 MHz reference clock; all serial timing is sampled from it.
*/
package nvm_pkg;

  // memory geometry
  localparam int unsigned ROW_W    = 5;     // row address width
  localparam int unsigned WORD_W   = 16;    // row word width
  localparam int unsigned ROWS     = 32;    // number of rows

  // bit counter marks within one serial byte
  localparam logic [3:0]  CNT_ZERO = 4'h0;  // first bit slot
  localparam logic [3:0]  CNT_LAST = 4'h7;  // eighth data bit
  localparam logic [3:0]  CNT_ACK  = 4'h8;  // acknowledge slot
  localparam logic [1:0]  RX_MAX   = 2'h2;  // most data bytes a write takes

  // special mode control bytes: 11xxx111
  localparam logic [7:0]  SPEC_MASK  = 8'hC7;
  localparam logic [7:0]  SPEC_VAL   = 8'hC7;
  localparam int unsigned PM_BIT     = 3;   // 1: automatic power switching on
  localparam int unsigned MANCH_BIT  = 4;   // 1: manchester, 0: bi-phase
  localparam int unsigned MOD_OFF_BIT = 5;  // 0: command selects the modulator

  // erase-write cycle time
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned T_WRITE_US   = 10_000;
  localparam int unsigned WRITE_CYCLES = T_WRITE_US * CLK_MHZ;
  localparam int unsigned BUSY_W       = 21;

  // control byte layout, msb first
  typedef struct packed {
    logic [ROW_W-1:0] row;                  // row_addr_msb .. row_addr_lsb
    logic             order_select_hi;
    logic             order_select_lo;
    logic             read_not_write_bit;
  } ctrl_byte_s;

  // request into the row store
  typedef struct packed {
    logic              rd_en;
    logic              wr_en;
    logic [ROW_W-1:0]  addr;
    logic [WORD_W-1:0] wdata;
  } mem_req_s;

  // serial protocol states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_CTRL = 6'b00_0010,
    ST_RX   = 6'b00_0100,
    ST_TX   = 6'b00_1000,
    ST_MOD  = 6'b01_0000,
    ST_WAIT = 6'b10_0000
  } proto_state_e;

endpackage : nvm_pkg

// >>> verilog/nvm_row_store.sv
/*
  row store: 32 rows of 16 bits with registered read data.
  assumes requests come from the serial front end on the same clock.
*/
`timescale 1ns/100ps
module nvm_row_store (
  // clock and reset
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst,
  // request and read data
  input  wire nvm_pkg::mem_req_s         i_req,
  output logic [nvm_pkg::WORD_W-1:0]     o_rd_data
);

  // cell array, no reset: contents are meant to persist
  logic [nvm_pkg::WORD_W-1:0] cells [nvm_pkg::ROWS];

  // write port
  always_ff @(posedge i_ref_clk)
  begin
    if (i_req.wr_en)
      cells[i_req.addr] <= i_req.wdata;
  end

  // read data leaves through a register
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      o_rd_data <= '0;
    else if (i_req.rd_en)
      o_rd_data <= cells[i_req.addr];
  end

endmodule : nvm_row_store

// >>> verilog/twowire_eeprom_mode_interface.sv
/*
  slave side of the two-wire serial port: row reads and writes through a word
  buffer, power management and modulator mode commands.
  assumes scl and sda arrive asynchronously and are oversampled by i_ref_clk;
  the open-drain sda wire is resolved outside from o_sda_oe.
*/
`timescale 1ns/100ps
module twowire_eeprom_mode_interface #(
  parameter int unsigned WRITE_CYCLES = nvm_pkg::WRITE_CYCLES  // erase-write length in clocks
) (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // serial pins
  input  wire logic i_scl,
  input  wire logic i_sda_in,
  output logic      o_sda_out,
  output logic      o_sda_oe,
  // status and modes
  output logic      o_standby,
  output logic      o_busy,
  output logic      o_pm_auto_en,
  output logic      o_mod_active,
  output logic      o_mod_manchester,
  output logic      o_mod_bit,
  output logic      o_mod_strobe
);

  logic [2:0]                  scl_sync_q;   // three-stage pin samplers
  logic [2:0]                  sda_sync_q;
  logic                        scl_q;        // settled levels
  logic                        sda_q;
  logic                        scl_new;
  logic                        sda_new;
  logic                        scl_rise;
  logic                        scl_fall;
  logic                        rise_seen_q;  // a clock rise has come since the last start
  logic                        start_ev;
  logic                        stop_ev;
  nvm_pkg::proto_state_e       st_q;
  logic [3:0]                  cnt_q;        // bit slot within a byte
  logic [7:0]                  shift_q;      // receive shifter
  logic [7:0]                  tx_q;         // transmit shifter
  logic                        ack_ok_q;     // master acknowledged last byte
  logic [1:0]                  nbytes_q;     // data bytes taken by a write
  logic                        half_q;       // 0: first byte of word next
  logic                        mode_hi_q;    // high byte first, decrement
  logic [nvm_pkg::ROW_W-1:0]   row_q;
  logic [nvm_pkg::WORD_W-1:0]  buf_q;        // word buffer
  logic [nvm_pkg::WORD_W-1:0]  rd_data;
  logic                        rd_req_q;
  logic                        rd_pend_q;
  logic                        busy_q;
  logic [nvm_pkg::BUSY_W-1:0]  busy_cnt_q;
  nvm_pkg::mem_req_s           req;
  nvm_pkg::ctrl_byte_s         ctrl;
  logic                        special;
  logic                        rx_done;
  logic                        ctrl_done;
  logic                        ack_end;
  logic                        tx_load;
  logic                        commit;
  logic                        byte_hi;
  logic [7:0]                  tx_byte;

  // synchronisers; the first stage feeds only the second
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[1:0], i_scl};
      sda_sync_q <= {sda_sync_q[1:0], i_sda_in};
    end
  end

  // a level counts once stages two and three agree
  assign scl_new = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_q;
  assign sda_new = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_q;

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_new;
      sda_q <= sda_new;
    end
  end

  // events; a data edge with clock high never reaches the shifter
  assign scl_rise = scl_new & ~scl_q;
  // the fall that closes a start carries no bit, so it is not counted
  assign scl_fall = ~scl_new & scl_q & rise_seen_q;
  assign start_ev = sda_q & ~sda_new & scl_q & scl_new & (st_q == nvm_pkg::ST_IDLE);
  // falling data outside standby ends a transfer, as does the usual rising edge
  assign stop_ev  = scl_q & scl_new & (sda_q != sda_new) & ~start_ev & (st_q != nvm_pkg::ST_IDLE);

  // falls count only once a bit clock has risen; without this the
  // start's own clock fall would eat a bit slot of the control byte
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      rise_seen_q <= 1'b0;
    else if (start_ev)
      rise_seen_q <= 1'b0;
    else if (scl_rise)
      rise_seen_q <= 1'b1;
  end

  // control byte decode
  assign ctrl      = nvm_pkg::ctrl_byte_s'(shift_q);
  assign special   = (shift_q & nvm_pkg::SPEC_MASK) == nvm_pkg::SPEC_VAL;
  assign rx_done   = scl_fall & (cnt_q == nvm_pkg::CNT_LAST) &
                     ((st_q == nvm_pkg::ST_CTRL) | (st_q == nvm_pkg::ST_RX));
  assign ctrl_done = rx_done & (st_q == nvm_pkg::ST_CTRL);
  assign ack_end   = scl_fall & (cnt_q == nvm_pkg::CNT_ACK);
  assign tx_load   = ack_end & (st_q == nvm_pkg::ST_TX) & ack_ok_q;
  assign commit    = stop_ev & (st_q == nvm_pkg::ST_RX) & (nbytes_q != 2'h0);
  // which buffer half the current byte uses
  assign byte_hi   = half_q ? ~mode_hi_q : mode_hi_q;
  assign tx_byte   = byte_hi ? buf_q[15:8] : buf_q[7:0];

  // serial protocol: state, bit count, shifters, data pin drive
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_q     <= nvm_pkg::ST_IDLE;
      cnt_q    <= nvm_pkg::CNT_ZERO;
      shift_q  <= 8'h00;
      tx_q     <= 8'h00;
      o_sda_oe <= 1'b0;
      ack_ok_q <= 1'b0;
      nbytes_q <= 2'h0;
    end
    else if (stop_ev)
    begin
      st_q     <= nvm_pkg::ST_IDLE;
      o_sda_oe <= 1'b0;
    end
    else if (start_ev)
    begin
      st_q     <= nvm_pkg::ST_CTRL;
      cnt_q    <= nvm_pkg::CNT_ZERO;
      o_sda_oe <= 1'b0;
      nbytes_q <= 2'h0;
    end
    else
    begin
      // data is taken on the rising clock
      if (scl_rise && cnt_q != nvm_pkg::CNT_ACK)
        shift_q <= {shift_q[6:0], sda_q};
      // our own drive counts as acknowledged
      if (scl_rise && cnt_q == nvm_pkg::CNT_ACK && st_q == nvm_pkg::ST_TX)
        ack_ok_q <= o_sda_oe | ~sda_q;
      if (ack_end)
      begin
        cnt_q <= nvm_pkg::CNT_ZERO;
        // next byte goes out only after an acknowledge
        o_sda_oe <= tx_load & ~tx_byte[7];
        tx_q     <= {tx_byte[6:0], 1'b0};
        if (st_q == nvm_pkg::ST_TX && !ack_ok_q)
          st_q <= nvm_pkg::ST_WAIT;
      end
      else if (scl_fall)
      begin
        unique case (st_q)
          nvm_pkg::ST_CTRL:
          begin
            if (cnt_q == nvm_pkg::CNT_LAST)
            begin
              cnt_q    <= nvm_pkg::CNT_ACK;
              o_sda_oe <= ~busy_q;
              ack_ok_q <= 1'b1;
              if (busy_q)
                st_q <= nvm_pkg::ST_WAIT;
              else if (special)
                st_q <= shift_q[nvm_pkg::MOD_OFF_BIT] ? nvm_pkg::ST_WAIT : nvm_pkg::ST_MOD;
              else
                st_q <= ctrl.read_not_write_bit ? nvm_pkg::ST_TX : nvm_pkg::ST_RX;
            end
            else
              cnt_q <= cnt_q + 4'h1;
          end
          nvm_pkg::ST_RX:
          begin
            if (cnt_q == nvm_pkg::CNT_LAST)
            begin
              cnt_q    <= nvm_pkg::CNT_ACK;
              o_sda_oe <= nbytes_q != nvm_pkg::RX_MAX;
              if (nbytes_q != nvm_pkg::RX_MAX)
                nbytes_q <= nbytes_q + 2'h1;
            end
            else
              cnt_q <= cnt_q + 4'h1;
          end
          nvm_pkg::ST_TX:
          begin
            if (cnt_q == nvm_pkg::CNT_LAST)
            begin
              cnt_q    <= nvm_pkg::CNT_ACK;
              o_sda_oe <= 1'b0;  // master acknowledges here
            end
            else
            begin
              cnt_q    <= cnt_q + 4'h1;
              o_sda_oe <= ~tx_q[7];
              tx_q     <= {tx_q[6:0], 1'b0};
            end
          end
          nvm_pkg::ST_IDLE, nvm_pkg::ST_MOD, nvm_pkg::ST_WAIT:
          begin
            // modulator bits and ignored clocks leave the counter alone
          end
        endcase
      end
    end
  end

  // row address, word buffer and row store traffic
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      row_q     <= '0;
      mode_hi_q <= 1'b0;
      half_q    <= 1'b0;
      buf_q     <= '0;
      rd_req_q  <= 1'b0;
      rd_pend_q <= 1'b0;
    end
    else
    begin
      rd_req_q  <= 1'b0;
      rd_pend_q <= rd_req_q;
      if (rd_pend_q)
        buf_q <= rd_data;
      if (ctrl_done && !busy_q && !special)
      begin
        row_q     <= ctrl.row;
        mode_hi_q <= ctrl.order_select_hi;
        half_q    <= 1'b0;
        rd_req_q  <= 1'b1;
      end
      else if (tx_load)
      begin
        half_q <= ~half_q;
        // second byte is loaded into the shifter, so fetch the next row
        if (half_q)
        begin
          row_q    <= mode_hi_q ? row_q - 5'h01 : row_q + 5'h01;
          rd_req_q <= 1'b1;
        end
      end
      else if (rx_done && st_q == nvm_pkg::ST_RX && nbytes_q != nvm_pkg::RX_MAX)
      begin
        half_q <= ~half_q;
        if (byte_hi)
          buf_q[15:8] <= shift_q;
        else
          buf_q[7:0] <= shift_q;
      end
    end
  end

  assign req.rd_en = rd_req_q;
  assign req.wr_en = commit & ~busy_q;
  assign req.addr  = row_q;
  assign req.wdata = buf_q;

  nvm_row_store nvm_row_store_inst (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_req     (req),
    .o_rd_data (rd_data)
  );

  // erase-write timer; the pins are deaf to control bytes meanwhile
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      busy_q     <= 1'b0;
      busy_cnt_q <= '0;
    end
    else if (commit && !busy_q)
    begin
      busy_q     <= 1'b1;
      busy_cnt_q <= nvm_pkg::BUSY_W'(WRITE_CYCLES - 1);
    end
    else if (busy_cnt_q != '0)
      busy_cnt_q <= busy_cnt_q - 1'b1;
    else
      busy_q <= 1'b0;
  end

  // mode commands and modulator stream
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_pm_auto_en     <= 1'b1;  // automatic switching after power-on
      o_mod_active     <= 1'b0;
      o_mod_manchester <= 1'b0;
      o_mod_bit        <= 1'b0;
      o_mod_strobe     <= 1'b0;
    end
    else
    begin
      o_mod_strobe <= 1'b0;
      if (ctrl_done && !busy_q && special)
      begin
        o_pm_auto_en <= shift_q[nvm_pkg::PM_BIT];
        if (!shift_q[nvm_pkg::MOD_OFF_BIT])
        begin
          o_mod_active     <= 1'b1;
          o_mod_manchester <= shift_q[nvm_pkg::MANCH_BIT];
        end
      end
      // each clock after the acknowledge carries one stream bit
      if (st_q == nvm_pkg::ST_MOD && scl_rise && cnt_q == nvm_pkg::CNT_ZERO)
      begin
        o_mod_bit    <= sda_q;
        o_mod_strobe <= 1'b1;
      end
    end
  end

  // standby flag and static pin level
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_standby <= 1'b1;
      o_busy    <= 1'b0;
      o_sda_out <= 1'b0;  // open drain: only ever pulls low
    end
    else
    begin
      o_busy <= busy_q;
      if (start_ev)
        o_standby <= 1'b0;
      else if (stop_ev)
        o_standby <= 1'b1;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  idle_release_a: assert property (st_q == nvm_pkg::ST_IDLE |-> !o_sda_oe)
    else $error("data pin driven in standby");
  stop_standby_a: assert property (stop_ev |=> st_q == nvm_pkg::ST_IDLE && o_standby)
    else $error("stop did not return to standby");
  start_ctrl_a: assert property (start_ev |=> st_q == nvm_pkg::ST_CTRL && cnt_q == 4'h0)
    else $error("start did not open control byte");
  framing_shift_a: assert property (start_ev || stop_ev |=> $stable(shift_q))
    else $error("framing edge shifted as data");
  busy_nack_a: assert property (ctrl_done && busy_q |=> !o_sda_oe && st_q == nvm_pkg::ST_WAIT)
    else $error("control byte acknowledged while busy");
  dir_decode_a: assert property (ctrl_done && !busy_q && !special
                                 |=> (st_q == nvm_pkg::ST_TX) == $past(shift_q[0]))
    else $error("direction bit decoded wrong");
  pm_cmd_a: assert property (ctrl_done && !busy_q && special
                             |=> o_pm_auto_en == $past(shift_q[3]) ##1 $stable(o_pm_auto_en))
    else $error("power command not applied");
  nack_quit_a: assert property (ack_end && st_q == nvm_pkg::ST_TX && !ack_ok_q
                                |=> st_q == nvm_pkg::ST_WAIT && !o_sda_oe)
    else $error("sending went on after no acknowledge");
  row_step_a: assert property (tx_load && half_q |=> row_q == ($past(mode_hi_q) ?
                               5'($past(row_q) - 5'h01) : 5'($past(row_q) + 5'h01)))
    else $error("sequential row step wrong");
  write_limit_a: assert property (rx_done && st_q == nvm_pkg::ST_RX && nbytes_q == 2'h2
                                  |=> !o_sda_oe)
    else $error("third write byte acknowledged");
  commit_busy_a: assert property (commit && !busy_q |=> busy_q [*3])
    else $error("erase-write cycle not started");

  read_word_c: cover property (tx_load && half_q);
  write_commit_c: cover property (commit && !busy_q);
  pm_cmd_c: cover property (ctrl_done && special && !busy_q);
  mod_bit_c: cover property (o_mod_strobe);

endmodule : twowire_eeprom_mode_interface

// >>> verification/nvm_master_model.sv
/*
  behavioural master for the two-wire port: makes scl, drives sda and resolves the wire.
  assumes the device pulls sda low while i_sda_oe is high and that the wire has a pull-up.
*/
`timescale 1ns/100ps
module nvm_master_model (
  // device side of the wire
  input  wire logic i_sda_oe,
  // resolved serial lines
  output logic      o_scl,
  output logic      o_sda
);
  localparam realtime QTR = 31.25;  // quarter of the 125 ns bit period

  logic sda_rel;                    // 1: master lets the wire float high

  // open-drain wire: pull-up unless any party pulls low
  assign o_sda = sda_rel & ~i_sda_oe;

  // clock stands high outside frames, master owns it
  initial
  begin
    o_scl   = 1'b1;
    sda_rel = 1'b1;
  end

  // start: data falls while the clock is high
  task automatic start_cond();
    sda_rel = 1'b1;
    #QTR sda_rel = 1'b0;
    #QTR o_scl = 1'b0;
    #QTR;
  endtask : start_cond

  // stop: one data edge with the clock high, either polarity
  task automatic stop_cond(input logic falling);
    sda_rel = falling;
    #QTR o_scl = 1'b1;
    #QTR sda_rel = ~falling;
    // back high after a falling stop; a rising edge in standby is no start
    #QTR sda_rel = 1'b1;
    #QTR;
  endtask : stop_cond

  // one clock: data set only while the clock is low, sampled in the high phase
  task automatic clk_bit(input logic b, output logic s);
    sda_rel = b;
    #QTR o_scl = 1'b1;
    #QTR s = o_sda;
    #QTR o_scl = 1'b0;
    #QTR;
  endtask : clk_bit

  // byte out, msb first, then a released ninth clock; ack is 1 when pulled low
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : wr_byte

  // byte in, then acknowledge or withhold it on the ninth clock
  task automatic rd_byte(input logic ack_it, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b1, b[i]);
    clk_bit(~ack_it, s);
  endtask : rd_byte
endmodule : nvm_master_model

// >>> verification/twowire_eeprom_mode_interface_tb.sv
/*
  self-checking bench for the two-wire row access front end.
  assumes the master model drives the wire; erase-write time is shortened to WC clocks.
*/
`timescale 1ns/100ps
module twowire_eeprom_mode_interface_tb;
  localparam int unsigned WC = 400;  // long enough to poll once while busy

  // clock, reset and wire
  logic        i_ref_clk;
  logic        i_rst;
  logic        scl;
  logic        sda;
  // device outputs
  logic        sda_out;
  logic        sda_oe;
  logic        standby;
  logic        busy;
  logic        pm_auto_en;
  logic        mod_active;
  logic        mod_manch;
  logic        mod_bit;
  logic        mod_strobe;
  // expectations and bookkeeping
  logic [15:0] exp_mem [32];         // row contents as the bench expects them
  logic [7:0]  mod_sh     = 8'h00;   // stream bits seen at the strobe
  int          strobe_cnt = 0;
  int          error_cnt  = 0;
  int          check_count = 0;

  nvm_master_model nvm_master_model_inst (
    .i_sda_oe (sda_oe),
    .o_scl    (scl),
    .o_sda    (sda)
  );

  twowire_eeprom_mode_interface #(.WRITE_CYCLES(WC)) twowire_eeprom_mode_interface_inst (
    .i_ref_clk        (i_ref_clk),
    .i_rst            (i_rst),
    .i_scl            (scl),
    .i_sda_in         (sda),
    .o_sda_out        (sda_out),
    .o_sda_oe         (sda_oe),
    .o_standby        (standby),
    .o_busy           (busy),
    .o_pm_auto_en     (pm_auto_en),
    .o_mod_active     (mod_active),
    .o_mod_manchester (mod_manch),
    .o_mod_bit        (mod_bit),
    .o_mod_strobe     (mod_strobe)
  );

  // reference clock, 8 ns period
  initial
  begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  // collect modulator stream bits as the device reports them
  always_ff @(posedge i_ref_clk)
    if (mod_strobe === 1'b1)
    begin
      strobe_cnt <= strobe_cnt + 1;
      mod_sh     <= {mod_sh[6:0], mod_bit};
    end

  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  // control byte: row, order bits, direction
  function automatic logic [7:0] ctrl_byte(input logic [4:0] row, input logic hi, input logic rd);
    return {row, hi, ~hi, rd};
  endfunction : ctrl_byte

  // byte idx of a word in the chosen order
  function automatic logic [7:0] pick(input logic [15:0] w, input logic hi, input int idx);
    return ((idx == 0) == hi) ? w[15:8] : w[7:0];
  endfunction : pick

  task automatic open_frame(input logic [7:0] c, input logic exp_ack);
    logic a;
    nvm_master_model_inst.start_cond();
    chk1(standby, 1'b0);
    nvm_master_model_inst.wr_byte(c, a);
    chk1(a, exp_ack);
  endtask : open_frame

  // random stop polarity exercises both data edges
  task automatic close_frame();
    nvm_master_model_inst.stop_cond(1'($urandom));
    #100;
    chk1(standby, 1'b1);
    chk1(sda_oe, 1'b0);
  endtask : close_frame

  // busy must rise after a write stop and end near WC clocks
  task automatic wait_busy(input logic len_chk);
    int n;
    chk1(busy, 1'b1);
    n = 0;
    while (busy === 1'b1 && n < WC + 50)
    begin
      @(posedge i_ref_clk);
      n++;
    end
    if (n >= WC + 50)
    begin
      chk1(busy, 1'b0);
      summarize();
    end
    if (len_chk)
      chk1(n >= WC - 30 && n <= WC, 1'b1);
  endtask : wait_busy

  // write n data bytes, optionally polling while busy
  task automatic wr_row(input logic [4:0] row, input logic hi, input logic [15:0] w, input int n,
                        input logic poll);
    logic a;
    open_frame(ctrl_byte(row, hi, 1'b0), 1'b1);
    for (int i = 0; i < n; i++)
    begin
      nvm_master_model_inst.wr_byte(pick(w, hi, i % 2), a);
      chk1(a, 1'(i < 2));
    end
    close_frame();
    if (n >= 2)
      exp_mem[row] = w;
    else if (hi)
      exp_mem[row][15:8] = w[15:8];
    else
      exp_mem[row][7:0] = w[7:0];
    // acknowledge polling is refused while the cell is written
    if (poll)
    begin
      open_frame(ctrl_byte(row, hi, 1'b1), 1'b0);
      close_frame();
    end
    wait_busy(~poll);
  endtask : wr_row

  // sequential read of nb bytes, nack on the last one
  task automatic rd_seq(input logic [4:0] row, input logic hi, input int nb);
    logic [7:0] b;
    logic [4:0] r;
    open_frame(ctrl_byte(row, hi, 1'b1), 1'b1);
    r = row;
    for (int i = 0; i < nb; i++)
    begin
      nvm_master_model_inst.rd_byte(1'(i < nb - 1), b);
      chk8(b, pick(exp_mem[r], hi, i % 2));
      if (i % 2 == 1)
        r = hi ? r - 5'h1 : r + 5'h1;
    end
    // after the nack the device must stay off the wire
    #50;
    chk1(sda_oe, 1'b0);
    close_frame();
  endtask : rd_seq

  initial
  begin
    logic       s;
    logic [7:0] bits;
    int         c0;
    i_rst = 1'b1;
    void'($urandom(12630));
    repeat (4) @(posedge i_ref_clk);
    #1 i_rst = 1'b0;
    repeat (10) @(posedge i_ref_clk);
    chk1(standby, 1'b1);
    chk1(sda_oe, 1'b0);
    chk1(busy, 1'b0);
    chk1(pm_auto_en, 1'b1);
    chk1(mod_active, 1'b0);
    chk1(sda_out, 1'b0);
    // fill every row, polling once while busy
    for (int i = 0; i < 32; i++)
      wr_row(5'(i), 1'($urandom), 16'($urandom), 2, 1'(i == 3));
    wr_row(5'h05, 1'b1, 16'($urandom), 1, 1'b0);
    wr_row(5'h0A, 1'b0, 16'($urandom), 1, 1'b0);
    wr_row(5'h09, 1'b0, 16'($urandom), 3, 1'b0);
    // wrap both ways, then random sequential reads
    rd_seq(5'h1F, 1'b0, 6);
    rd_seq(5'h00, 1'b1, 6);
    rd_seq(5'h05, 1'b1, 2);
    rd_seq(5'h0A, 1'b0, 2);
    repeat (6)
      rd_seq(5'($urandom), 1'($urandom), 1 + ($urandom % 5));
    // power management off holds through other traffic
    open_frame(8'hE7, 1'b1);
    close_frame();
    chk1(pm_auto_en, 1'b0);
    rd_seq(5'h09, 1'b1, 2);
    chk1(pm_auto_en, 1'b0);
    open_frame(8'hEF, 1'b1);
    close_frame();
    chk1(pm_auto_en, 1'b1);
    // manchester stream: one strobe per clock after the acknowledge
    open_frame(8'hDF, 1'b1);
    chk1(mod_active, 1'b1);
    chk1(mod_manch, 1'b1);
    c0 = strobe_cnt;
    bits = 8'($urandom);
    for (int i = 7; i >= 0; i--)
      nvm_master_model_inst.clk_bit(bits[i], s);
    #40;
    chk8(8'(strobe_cnt - c0), 8'h08);
    chk8(mod_sh, bits);
    close_frame();
    open_frame(8'hCF, 1'b1);
    chk1(mod_manch, 1'b0);
    chk1(mod_active, 1'b1);
    close_frame();
    summarize();
  end
endmodule : twowire_eeprom_mode_interface_tb
